//--- hw/srt_core.sv
// Our own choices: the register offsets and register access over Wishbone.
`include "srt_consts.svh"
module srt_core import srt_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // live current status word
  output logic      [31:0] cur_status_o
);

  // ==================== functions
  function automatic logic [2:0] bank_idx(input logic [4:0] m);
    case (m)
      `SRT_MODE_FIQ: bank_idx = 3'h0;
      `SRT_MODE_IRQ: bank_idx = 3'h1;
      `SRT_MODE_SVC: bank_idx = 3'h2;
      `SRT_MODE_ABT: bank_idx = 3'h3;
      `SRT_MODE_UND: bank_idx = 3'h4;
      default:       bank_idx = 3'h7;
    endcase
  endfunction

  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    case (c)
      4'h0:    cond_pass = z;
      4'h1:    cond_pass = !z;
      4'h2:    cond_pass = cy;
      4'h3:    cond_pass = !cy;
      4'h4:    cond_pass = n;
      4'h5:    cond_pass = !n;
      4'h6:    cond_pass = v;
      4'h7:    cond_pass = !v;
      4'h8:    cond_pass = cy && !z;
      4'h9:    cond_pass = !cy || z;
      4'ha:    cond_pass = (n == v);
      4'hb:    cond_pass = (n != v);
      4'hc:    cond_pass = !z && (n == v);
      4'hd:    cond_pass = z || (n != v);
      4'he:    cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    byte_merge = r;
  endfunction

  // ==================== reset release
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_sync_n = rst_s2_r;

  // ==================== state
  logic [31:0] cur_r;
  logic [31:0] saved_r [0:4];
  logic [31:0] gpr_r   [0:15];
  logic [31:0] instr_r;
  logic        ill_r, skip_r, done_r;
  srt_state_t  state_r, state_nxt;

  // ==================== bus decode
  wire logic       bus_req   = wb_cyc_i && wb_stb_i;
  wire logic       bus_wr    = bus_req && wb_we_i && wb_ack_o;
  wire logic       adr_gpr   = (wb_adr_i[7:6] == 2'b01);
  wire logic [3:0] adr_gidx  = wb_adr_i[5:2];
  wire logic       wr_instr  = bus_wr && (wb_adr_i == `SRT_OFS_INSTR) && (wb_sel_i == 4'hf);
  wire logic       wr_gpr    = bus_wr && adr_gpr;
  wire logic [2:0] cur_bank  = bank_idx(cur_r[4:0]);
  wire logic       has_saved = (cur_bank != 3'h7);
  wire logic [31:0] saved_rd = has_saved ? saved_r[cur_bank] : cur_r;
  wire logic [31:0] stat_rd  = {28'h0, done_r, skip_r, ill_r, (state_r == SRT_EXEC)};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (adr_gpr) begin
      rd_mux = gpr_r[adr_gidx];
    end else begin
      case (wb_adr_i)
        `SRT_OFS_INSTR: rd_mux = instr_r;
        `SRT_OFS_CUR:   rd_mux = cur_r;
        `SRT_OFS_SAVED: rd_mux = saved_rd;
        `SRT_OFS_STAT:  rd_mux = stat_rd;
        default:        rd_mux = 32'h0;
      endcase
    end
  end

  // ==================== instruction decode
  wire logic [3:0]  i_cond  = instr_r[31:28];
  wire logic        i_imm   = instr_r[25];
  wire logic        i_saved = instr_r[22];
  wire logic [3:0]  i_rd    = instr_r[15:12];
  wire logic [3:0]  i_rm    = instr_r[3:0];
  wire logic [4:0]  i_rot2  = {instr_r[11:8], 1'b0};
  wire logic [31:0] i_imm8  = {24'h0, instr_r[7:0]};
  wire logic [31:0] imm_val = (i_imm8 >> i_rot2) | (i_imm8 << (6'd32 - {1'b0, i_rot2}));
  wire logic        is_read  = (instr_r[27:23] == 5'b00010) && (instr_r[21:16] == 6'h0f)
                               && (instr_r[11:0] == 12'h0);
  wire logic        is_whole = (instr_r[27:23] == 5'b00010) && (instr_r[21:12] == 10'h29f)
                               && (instr_r[11:4] == 8'h0) && !i_imm;
  wire logic        is_flags = (instr_r[27:26] == 2'b00) && (instr_r[24:23] == 2'b10)
                               && (instr_r[21:12] == 10'h28f)
                               && (i_imm || (instr_r[11:4] == 8'h0));
  srt_op_t op;
  always_comb begin
    op = SRT_OP_NONE;
    if (is_read) begin
      op = SRT_OP_READ;
    end else if (is_whole) begin
      op = SRT_OP_WHOLE;
    end else if (is_flags) begin
      op = SRT_OP_FLAGS;
    end
  end
  wire logic uses_pc = (op == SRT_OP_READ) ? (i_rd == `SRT_PC_IDX)
                     : (!i_imm && (i_rm == `SRT_PC_IDX));
  wire logic illegal = (op == SRT_OP_NONE) || uses_pc;
  wire logic passed  = cond_pass(i_cond, cur_r[31:28]);
  wire logic commit  = (state_r == SRT_EXEC) && !illegal && passed;
  wire logic        priv   = (cur_r[4:0] != `SRT_MODE_USR);
  wire logic [31:0] src    = (op == SRT_OP_FLAGS && i_imm) ? imm_val : gpr_r[i_rm];
  wire logic [31:0] src_fl = src & `SRT_FLAG_MASK;
  wire logic [31:0] src_im = src & `SRT_IMPL_MASK;

  // ==================== next status words
  logic [31:0] cur_nxt, sav_nxt;
  always_comb begin
    cur_nxt = cur_r;
    sav_nxt = saved_rd;
    if (op == SRT_OP_WHOLE) begin
      // user and system mode have no bank, so wr_saved drops a saved write there
      if (i_saved) begin
        sav_nxt = src_im;
      end else if (!priv) begin
        cur_nxt = (cur_r & ~`SRT_FLAG_MASK) | src_fl;
      end else begin
        cur_nxt = src_im;
      end
    end else if (op == SRT_OP_FLAGS) begin
      if (i_saved) begin
        sav_nxt = (saved_rd & ~`SRT_FLAG_MASK) | src_fl;
      end else begin
        cur_nxt = (cur_r & ~`SRT_FLAG_MASK) | src_fl;
      end
    end
  end
  wire logic        wr_saved = commit && i_saved && has_saved && (op != SRT_OP_READ);
  wire logic        wr_rd    = commit && (op == SRT_OP_READ);
  wire logic [31:0] rd_val   = i_saved ? saved_rd : cur_r;

  // ==================== sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SRT_IDLE: if (wr_instr) state_nxt = SRT_EXEC;
      SRT_EXEC: state_nxt = SRT_IDLE;
      default:  state_nxt = SRT_IDLE;
    endcase
  end

  // ==================== bus slave registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // ==================== sequencer register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= SRT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==================== instruction latch
  // a write while executing is dropped, so the word never shifts under a commit
  wire logic take_instr = wr_instr && (state_r == SRT_IDLE);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      instr_r <= 32'h0;
    end else if (take_instr) begin
      instr_r <= wb_dat_i;
    end
  end

  // ==================== completion flags
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ill_r  <= 1'b0;
      skip_r <= 1'b0;
      done_r <= 1'b0;
    end else if (state_r == SRT_EXEC) begin
      ill_r  <= illegal;
      skip_r <= !illegal && !passed;
      done_r <= 1'b1;
    end else if (take_instr) begin
      done_r <= 1'b0;
    end
  end

  // ==================== current status word
  // the port copy is its own flop, so it never shows decode glitches
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur_r        <= `SRT_CUR_RESET;
      cur_status_o <= `SRT_CUR_RESET;
    end else if (commit) begin
      cur_r        <= cur_nxt;
      cur_status_o <= cur_nxt;
    end
  end

  // ==================== saved status banks, one per banked mode: FIQ, IRQ, SVC, ABT, UND
  genvar gb;
  generate
    for (gb = 0; gb < 5; gb++) begin : g_bank
      wire logic bank_hit = wr_saved && (cur_bank == 3'(gb));
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          saved_r[gb] <= 32'h0;
        end else if (bank_hit) begin
          saved_r[gb] <= sav_nxt;
        end
      end
    end
  endgenerate

  // ==================== general registers
  // a status read and a bus write never meet: the bus is held off by the ack timing
  genvar gr;
  generate
    for (gr = 0; gr < 16; gr++) begin : g_gpr
      wire logic rd_hit  = wr_rd && (i_rd == 4'(gr));
      wire logic bus_hit = wr_gpr && (adr_gidx == 4'(gr));
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          gpr_r[gr] <= 32'h0;
        end else if (rd_hit) begin
          gpr_r[gr] <= rd_val;
        end else if (bus_hit) begin
          gpr_r[gr] <= byte_merge(gpr_r[gr], wb_dat_i, wb_sel_i);
        end
      end
    end
  endgenerate

endmodule // srt_core

//--- shared/srt_consts.svh
`ifndef SRT_CONSTS_SVH
`define SRT_CONSTS_SVH

// ==================== register offsets
`define SRT_OFS_INSTR   8'h00
`define SRT_OFS_CUR     8'h04
`define SRT_OFS_SAVED   8'h08
`define SRT_OFS_STAT    8'h0c
`define SRT_OFS_GPR     8'h40
// ==================== status word layout
`define SRT_IMPL_MASK   32'hf00000ff
`define SRT_FLAG_MASK   32'hf0000000
`define SRT_CUR_RESET   32'h000000d3
`define SRT_FLAG_N      31
`define SRT_FLAG_Z      30
`define SRT_FLAG_C      29
`define SRT_FLAG_V      28
// ==================== modes
`define SRT_MODE_USR    5'h10
`define SRT_MODE_FIQ    5'h11
`define SRT_MODE_IRQ    5'h12
`define SRT_MODE_SVC    5'h13
`define SRT_MODE_ABT    5'h17
`define SRT_MODE_UND    5'h1b
// ==================== status register bits
`define SRT_STAT_BUSY   0
`define SRT_STAT_ILL    1
`define SRT_STAT_SKIP   2
`define SRT_STAT_DONE   3
`define SRT_PC_IDX      4'hf
`endif

//--- shared/srt_pkg.sv
package srt_pkg;
  typedef enum logic [1:0] {
    SRT_IDLE = 2'b01,
    SRT_EXEC = 2'b10
  } srt_state_t;
  typedef enum logic [3:0] {
    SRT_OP_NONE  = 4'b0001,
    SRT_OP_READ  = 4'b0010,
    SRT_OP_WHOLE = 4'b0100,
    SRT_OP_FLAGS = 4'b1000
  } srt_op_t;
endpackage

//--- verif/srt_core_properties.sv
module srt_core_properties (
  // bus and status
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [31:0] cur_status_o
);
  // ====================
  // instruction decode as seen on the bus
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] c;
  logic [63:0] rr;
  logic        iw, al, fi, fr, wh;
  assign c  = wb_dat_i;
  assign iw = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i == 8'h00)
              & (wb_sel_i == 4'hf);
  assign al = iw & (c[31:28] == 4'he);
  assign fi = al & (c[27:23] == 5'b00110) & (c[21:12] == 10'h28f);
  assign fr = al & (c[27:23] == 5'b00010) & (c[21:12] == 10'h28f);
  assign wh = al & (c[27:22] == 6'b000100) & (c[21:12] == 10'h29f);
  assign rr = {2{24'h0, c[7:0]}} >> {c[11:8], 1'b0};
  // ====================
  // properties
  property p_rsv; (cur_status_o & 32'h0fffff00) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  property p_one; $changed(cur_status_o) |-> $past(iw, 2); endproperty
  a_one: assert property (p_one) else $error("status moved off the commit slot");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_imm; fi && !c[22] |-> ##2 cur_status_o[31:28] == $past(rr[31:28], 2); endproperty
  a_imm: assert property (p_imm) else $error("immediate flags wrong");
  property p_ctl; fi || fr |-> ##2 cur_status_o[7:0] == $past(cur_status_o[7:0], 2); endproperty
  a_ctl: assert property (p_ctl) else $error("flags write hit control bits");
  property p_usr;
    wh && cur_status_o[4:0] == 5'h10 |-> ##2 $past(cur_status_o[7:0], 2) == cur_status_o[7:0];
  endproperty
  a_usr: assert property (p_usr) else $error("user write hit control bits");
  property p_sav; fi && c[22] |-> ##2 cur_status_o == $past(cur_status_o, 2); endproperty
  a_sav: assert property (p_sav) else $error("saved write hit current word");
  property p_skip; iw && c[31:28] == 4'hf |-> ##2 cur_status_o == $past(cur_status_o, 2); endproperty
  a_skip: assert property (p_skip) else $error("failed condition still wrote");
  property p_rd; wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o == cur_status_o; endproperty
  a_rd: assert property (p_rd) else $error("current word read mismatch");
  c_fi: cover property (fi);
  c_usr: cover property (wh && cur_status_o[4:0] == 5'h10);
  c_skip: cover property (iw && c[31:28] == 4'hf);
endmodule // srt_core_properties

bind srt_core srt_core_properties srt_core_properties_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cur_status_o);

//--- verif/srt_host.sv
module srt_host (
  // clock
  input  wire logic        clk,
  // wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] wdat,
  input  wire logic        ack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
  end
  // ====================
  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~d; // scrambled so a stale word never looks valid
    @(posedge clk);
  endtask
endmodule // srt_host

//--- verif/test_status_register_transfer.sv
`include "srt_consts.svh"
module test_status_register_transfer;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // harness
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, cur_o, cur, sv, g2, lf, e_rd, q[$];
  logic [63:0] r;
  int          n_mismatch = 0;
  int          checks = 0;
  always #25 clk = ~clk;
  srt_core srt_core_i (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cur_status_o(cur_o));
  srt_host srt_host_i (.clk, .cyc, .stb, .we, .adr, .sel, .wdat, .ack);
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_cur(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t live=%h exp=%h", $time, g, e);
    end
  endtask
  // the live status port is checked beside every read of the current word
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0) begin
      e_rd = q.pop_front();
      cmp(rdat, e_rd);
      if (adr === 8'h04) cmp_cur(cur_o, e_rd);
    end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    srt_host_i.xfer(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    srt_host_i.xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    srt_host_i.xfer(1'b1, a, d, s);
  endtask
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
  // ====================
  // scenarios; register 15 is never named
  initial begin
    lf = 32'd21;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cur = `SRT_CUR_RESET;
    rd(8'h04, cur);
    rd(8'h20, 32'h0);
    lf = nx(lf);
    cur = (lf & 32'hf00000e0) | 32'h11;
    wr(8'h44, cur);
    wr(8'h00, 32'he129f001);
    rd(8'h04, cur);
    g2 = nx(lf);
    sv = g2 & `SRT_IMPL_MASK;
    wr(8'h48, g2);
    wr(8'h00, 32'he169f002);
    rd(8'h08, sv);
    wr(8'h00, 32'he14f4000);
    rd(8'h50, sv);
    wr(8'h00, 32'he10f3000);
    rd(8'h4c, cur);
    lf = g2;
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      r = {2{24'h0, lf[7:0]}} >> {lf[11:8], 1'b0};
      wr(8'h00, (i[0] ? 32'he368f000 : 32'he328f000) | {20'h0, lf[11:0]});
      if (i[0]) sv[31:28] = r[31:28];
      else cur[31:28] = r[31:28];
      rd(8'h04, cur);
      rd(8'h08, sv);
    end
    lf = nx(lf);
    wr(8'h54, lf);
    wr(8'h00, 32'he128f005);
    cur[31:28] = lf[31:28];
    rd(8'h04, cur);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, {(k == 0) ? {3'b000, cur[30]} : 4'hf, 28'h129f002});
      rd(8'h04, cur);
    end
    rd(8'h0c, 32'h0000000c);
    // unknown encoding: no effect, flagged illegal
    wr(8'h00, 32'he0000000);
    rd(8'h0c, 32'h0000000a);
    rd(8'h00, 32'he0000000);
    // instruction write with partial byte enables is ignored
    wrs(8'h00, 32'he129f002, 4'h7);
    rd(8'h00, 32'he0000000);
    rd(8'h04, cur);
    // general register write honours byte enables
    wrs(8'h5c, 32'ha5c35a3c, 4'h3);
    rd(8'h5c, 32'h00005a3c);
    cur = (cur & 32'hf00000e0) | 32'h10;
    wr(8'h58, cur);
    wr(8'h00, 32'he129f006);
    rd(8'h04, cur);
    wr(8'h00, 32'he129f002);
    cur[31:28] = g2[31:28];
    rd(8'h04, cur);
    rd(8'h08, cur);
    // user mode has no saved bank: a saved whole write must not touch the current word
    wr(8'h5c, ~cur);
    wr(8'h00, 32'he169f007);
    rd(8'h04, cur);
    rd(8'h08, cur);
    rd(8'h0c, 32'h00000008);
    summarize();
  end
endmodule // test_status_register_transfer
